// *** hdl/pic_top.v ***
// Pin interrupt controller: register file, per-channel detectors, request and wake outputs.
// Assumes a classic Wishbone master, one clock for bus and sampling, pins asynchronous.
// Assumes word-aligned byte addresses; the two low address bits are decoded as they come.
//
// What this block does
// - After reset all channels, NMI included, are disabled and raise nothing.
// - Trigger type bit: 0 selects edge, 1 selects level.
// - Edge polarity bit: 0 falling edge, 1 rising edge.
// - Level polarity bit: 0 low level, 1 high level.
// - Writing one to mask set sets the mask bit; zero does nothing.
// - Writing one to mask clear clears the mask bit; zero does nothing.
// - Mask state register reads back the current propagation mask.
// - A trigger sets the flag; it stays until cleared by software or disable.
// - Enable set and clear registers control inputs; enable state reads them back.
// - Enabled but masked channel still sets its flag and wake, no request.
// - Disabled channel flag reads zero; disabling clears it.
// - Synchronous pins pass two sampling flops, delaying the request two cycles.
// - Filter declares a condition held in two of the last three samples.
// - Bit 0 is the non-maskable channel, driving its own request, still gated.
// - Unclocked channels skip the filter; edge polarity becomes level polarity.
// - Unclocked wake, flag and request all rise together at the next edge.
// - With sampling stopped only unclocked channels act and raise wake.
// - Debug halt of the processor does not freeze this block.
// - Revision register at the top reads a configuration-dependent value.
// - Sampling is treated as stopped while the system RC oscillator is off.
`default_nettype none
`include "pic_map.vh"

module pic_top #(
    parameter NUM_CH = `PIC_MAX_CH,
    parameter [`PIC_DATA_W-1:0] REVISION = `PIC_REVISION_DEFAULT
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`PIC_ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [`PIC_DATA_W-1:0] wb_dat_i,
    output reg [`PIC_DATA_W-1:0] wb_dat_o,
    output reg wb_ack_o,
    // Pins and power state
    input wire [NUM_CH-1:0] ext_irq_pin_i,
    input wire system_rc_osc_on_i,
    // Requests
    output reg [NUM_CH-1:0] irq_o,
    output reg nmi_o,
    output reg wake_request_o
);

    // ****************************************************************
    // Register state
    // ****************************************************************
    reg [NUM_CH-1:0] mask_reg;
    reg [NUM_CH-1:0] mask_next;
    reg [NUM_CH-1:0] enable_reg;
    reg [NUM_CH-1:0] enable_next;
    reg [NUM_CH-1:0] flags_reg;
    reg [NUM_CH-1:0] flags_next;
    reg [NUM_CH-1:0] trig_type_reg;
    reg [NUM_CH-1:0] edge_pol_reg;
    reg [NUM_CH-1:0] level_pol_reg;
    reg [NUM_CH-1:0] filter_reg;
    reg [NUM_CH-1:0] unclocked_reg;
    reg [NUM_CH-1:0] test_reg;
    reg [`PIC_DATA_W-1:0] rd_next;

    wire req;
    wire wr;
    wire [`PIC_DATA_W-1:0] byte_mask;
    wire [NUM_CH-1:0] wdata;
    wire [NUM_CH-1:0] wmask;
    wire [NUM_CH-1:0] pin_sync;
    wire [NUM_CH-1:0] trig;
    wire [NUM_CH-1:0] unclocked_path_select_cond;
    wire run_sync;
    wire run;
    wire wr_mask_set;
    wire wr_mask_clear;
    wire wr_flag_clear;
    wire wr_enable_set;
    wire wr_enable_clear;
    wire wr_trig_type;
    wire wr_edge_pol;
    wire wr_level_pol;
    wire wr_filter;
    wire wr_test;
    wire wr_unclocked;
    wire [NUM_CH-1:0] lane_keep;
    wire [NUM_CH-1:0] flag_set;
    wire [NUM_CH-1:0] wake_src;
    wire [NUM_CH-1:0] irq_next;
    wire nmi_next;

    // Channel 0 only ever drives the non-maskable request.
    localparam [NUM_CH-1:0] NMI_SEL = {{(NUM_CH-1){1'b0}}, 1'b1};

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // One wait state: the request is taken and answered at the same edge.
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i;
    assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdata = wb_dat_i[NUM_CH-1:0];
    assign wmask = wdata & byte_mask[NUM_CH-1:0];
    assign lane_keep = ~byte_mask[NUM_CH-1:0];

    // ****************************************************************
    // Register write strobes
    // ****************************************************************
    // Each strobe lasts one cycle, because req drops while ack is high,
    // so a master that holds its request writes again every second cycle.
    assign wr_mask_set = wr && (wb_adr_i == `PIC_OFF_MASK_SET);
    assign wr_mask_clear = wr && (wb_adr_i == `PIC_OFF_MASK_CLEAR);
    assign wr_flag_clear = wr && (wb_adr_i == `PIC_OFF_EVENT_FLAG_CLEAR);
    assign wr_enable_set = wr && (wb_adr_i == `PIC_OFF_ENABLE_SET);
    assign wr_enable_clear = wr && (wb_adr_i == `PIC_OFF_ENABLE_CLEAR);
    assign wr_trig_type = wr && (wb_adr_i == `PIC_OFF_TRIGGER_TYPE);
    assign wr_edge_pol = wr && (wb_adr_i == `PIC_OFF_EDGE_POL);
    assign wr_level_pol = wr && (wb_adr_i == `PIC_OFF_LEVEL_POL);
    assign wr_filter = wr && (wb_adr_i == `PIC_OFF_FILTER_EN);
    assign wr_test = wr && (wb_adr_i == `PIC_OFF_TEST_CONTROL);
    assign wr_unclocked = wr && (wb_adr_i == `PIC_OFF_UNCLOCKED_SEL);

    // ****************************************************************
    // Pin synchronisers and sampling-clock state
    // ****************************************************************
    pic_sync #(
        .WIDTH(NUM_CH)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .unclocked_path_select_i(ext_irq_pin_i),
        .sync_o(pin_sync)
    );

    pic_sync #(
        .WIDTH(1)
    ) u_run_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .unclocked_path_select_i(system_rc_osc_on_i),
        .sync_o(run_sync)
    );

    // Synchronous detectors freeze while the RC oscillator is off.
    assign run = run_sync;

    // ****************************************************************
    // Channel detectors
    // ****************************************************************
    // No debug-halt input exists; only the RC oscillator being off freezes the detectors.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_chan
            pic_chan u_chan (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .pin_i(pin_sync[gi]),
                .run_i(run),
                .level_mode_i(trig_type_reg[gi]),
                .edge_pol_i(edge_pol_reg[gi]),
                .level_pol_i(level_pol_reg[gi]),
                .filter_i(filter_reg[gi]),
                .unclocked_i(unclocked_reg[gi]),
                .trig_o(trig[gi]),
                .unclocked_path_select_cond_o(unclocked_path_select_cond[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Next-state logic for mask, enable and event flags
    // ****************************************************************
    always @* begin
        mask_next = mask_reg;
        enable_next = enable_reg;
        if (wr_mask_set) begin
            mask_next = mask_reg | wmask;
        end
        if (wr_mask_clear) begin
            mask_next = mask_reg & ~wmask;
        end
        if (wr_enable_set) begin
            enable_next = enable_reg | wmask;
        end
        if (wr_enable_clear) begin
            enable_next = enable_reg & ~wmask;
        end
    end

    // A trigger in the clear cycle wins over the clear; disabling wins over both.
    always @* begin
        flags_next = flags_reg;
        if (wr_flag_clear) begin
            flags_next = flags_reg & ~wmask;
        end
        flags_next = (flags_next | flag_set) & enable_next;
    end

    // ****************************************************************
    // Request and wake sources
    // ****************************************************************
    // A channel collects triggers only once its enable has taken effect, so a
    // pin that was already active cannot slip in at the enabling edge.
    assign flag_set = trig & enable_reg;
    // Channel 0 goes to the non-maskable request only.
    assign irq_next = flags_next & mask_next & ~NMI_SEL;
    assign nmi_next = flags_next[`PIC_NMI_BIT] & mask_next[`PIC_NMI_BIT];
    // Unclocked channels raise wake from the raw condition too, so wake is never
    // later than the flag, and it stays up while any enabled flag is pending.
    assign wake_src = (unclocked_path_select_cond & enable_reg) | flags_next;

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    always @* begin
        rd_next = `PIC_RESET_WORD;
        case (wb_adr_i)
            `PIC_OFF_MASK_STATE: begin
                rd_next[NUM_CH-1:0] = mask_reg;
            end
            `PIC_OFF_EVENT_FLAGS: begin
                rd_next[NUM_CH-1:0] = flags_reg & enable_reg;
            end
            `PIC_OFF_TRIGGER_TYPE: begin
                rd_next[NUM_CH-1:0] = trig_type_reg;
            end
            `PIC_OFF_EDGE_POL: begin
                rd_next[NUM_CH-1:0] = edge_pol_reg;
            end
            `PIC_OFF_LEVEL_POL: begin
                rd_next[NUM_CH-1:0] = level_pol_reg;
            end
            `PIC_OFF_FILTER_EN: begin
                rd_next[NUM_CH-1:0] = filter_reg;
            end
            `PIC_OFF_TEST_CONTROL: begin
                rd_next[NUM_CH-1:0] = test_reg;
            end
            `PIC_OFF_UNCLOCKED_SEL: begin
                rd_next[NUM_CH-1:0] = unclocked_reg;
            end
            `PIC_OFF_ENABLE_STATE: begin
                rd_next[NUM_CH-1:0] = enable_reg;
            end
            `PIC_OFF_REVISION: begin
                rd_next = REVISION;
            end
            default: begin
                rd_next = `PIC_RESET_WORD;
            end
        endcase
    end

    // ****************************************************************
    // Mask, enable and event flag registers
    // ****************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= {NUM_CH{1'b0}};
            enable_reg <= {NUM_CH{1'b0}};
            flags_reg <= {NUM_CH{1'b0}};
        end else begin
            mask_reg <= mask_next;
            enable_reg <= enable_next;
            flags_reg <= flags_next;
        end
    end

    // ****************************************************************
    // Channel configuration registers
    // ****************************************************************
    // Byte lanes that sel leaves out keep their old configuration bits.
    always @(posedge clk_i) begin
        if (rst_i) begin
            trig_type_reg <= {NUM_CH{1'b0}};
            edge_pol_reg <= {NUM_CH{1'b0}};
            level_pol_reg <= {NUM_CH{1'b0}};
            filter_reg <= {NUM_CH{1'b0}};
            unclocked_reg <= {NUM_CH{1'b0}};
            test_reg <= {NUM_CH{1'b0}};
        end else begin
            if (wr_trig_type) begin
                trig_type_reg <= (trig_type_reg & lane_keep) | wmask;
            end
            if (wr_edge_pol) begin
                edge_pol_reg <= (edge_pol_reg & lane_keep) | wmask;
            end
            if (wr_level_pol) begin
                level_pol_reg <= (level_pol_reg & lane_keep) | wmask;
            end
            if (wr_filter) begin
                filter_reg <= (filter_reg & lane_keep) | wmask;
            end
            if (wr_unclocked) begin
                unclocked_reg <= (unclocked_reg & lane_keep) | wmask;
            end
            if (wr_test) begin
                test_reg <= (test_reg & lane_keep) | wmask;
            end
        end
    end

    // ****************************************************************
    // Bus answer
    // ****************************************************************
    // Read data is zero outside the ack cycle so a shared return bus can be OR-ed.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= `PIC_RESET_WORD;
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_next : `PIC_RESET_WORD;
        end
    end

    // ****************************************************************
    // Request and wake outputs
    // ****************************************************************
    // Every request leaves through a flop, so the far side never sees decode glitches.
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= {NUM_CH{1'b0}};
            nmi_o <= 1'b0;
            wake_request_o <= 1'b0;
        end else begin
            irq_o <= irq_next;
            nmi_o <= nmi_next;
            wake_request_o <= |wake_src;
        end
    end

endmodule // pic_top

`default_nettype wire

// *** hdl/pic_map.vh ***
// Register map and constants of the pin interrupt controller.
// Assumes a 32-bit classic Wishbone slave with byte addresses on a 10-bit window.
`ifndef PIC_MAP_VH
`define PIC_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PIC_ADR_W 10
`define PIC_OFF_MASK_SET 10'h000
`define PIC_OFF_MASK_CLEAR 10'h004
`define PIC_OFF_MASK_STATE 10'h008
`define PIC_OFF_EVENT_FLAGS 10'h00c
`define PIC_OFF_EVENT_FLAG_CLEAR 10'h010
`define PIC_OFF_TRIGGER_TYPE 10'h014
`define PIC_OFF_EDGE_POL 10'h018
`define PIC_OFF_LEVEL_POL 10'h01c
`define PIC_OFF_FILTER_EN 10'h020
`define PIC_OFF_TEST_CONTROL 10'h024
`define PIC_OFF_UNCLOCKED_SEL 10'h028
`define PIC_OFF_ENABLE_SET 10'h030
`define PIC_OFF_ENABLE_CLEAR 10'h034
`define PIC_OFF_ENABLE_STATE 10'h038
`define PIC_OFF_REVISION 10'h3fc

// ****************************************************************
// Widths, reset values and field positions
// ****************************************************************
`define PIC_DATA_W 32
`define PIC_MAX_CH 31
`define PIC_NMI_BIT 0
`define PIC_RESET_WORD 32'h0000_0000
// Arbitrary neutral revision value.
`define PIC_REVISION_DEFAULT 32'h0000_0100

`endif

// *** hdl/pic_sync.v ***
// Two flip-flop synchroniser for a vector of asynchronous pin levels.
// Assumes each bit is an independent level; no bus coherency is implied.
`default_nettype none

module pic_sync #(
    parameter WIDTH = 31
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Levels
    input wire [WIDTH-1:0] unclocked_path_select_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    // The first stage feeds only the second stage.
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= unclocked_path_select_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule // pic_sync

`default_nettype wire

// *** hdl/pic_chan.v ***
// One channel detector: majority filter, edge or level detection, unclocked-path level.
// Assumes the pin level has already passed the two flip-flop synchroniser.
`default_nettype none

module pic_chan (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Synchronised pin and configuration
    input wire pin_i,
    input wire run_i,
    input wire level_mode_i,
    input wire edge_pol_i,
    input wire level_pol_i,
    input wire filter_i,
    input wire unclocked_i,
    // Detection results
    output wire trig_o,
    output wire unclocked_path_select_cond_o
);

    reg hist1_reg;
    reg hist2_reg;
    reg filt_prev_reg;
    wire majority;
    wire filt_pin;
    wire level_hit;
    wire edge_hit;
    wire sync_trig;

    // Sample history only advances while the sampling clock runs.
    always @(posedge clk_i) begin
        if (rst_i) begin
            hist1_reg <= 1'b0;
            hist2_reg <= 1'b0;
            filt_prev_reg <= 1'b0;
        end else if (run_i) begin
            hist1_reg <= pin_i;
            hist2_reg <= hist1_reg;
            filt_prev_reg <= filt_pin;
        end
    end

    assign majority = (pin_i & hist1_reg) | (pin_i & hist2_reg) | (hist1_reg & hist2_reg);
    assign filt_pin = filter_i ? majority : pin_i;
    assign level_hit = (filt_pin == level_pol_i);
    assign edge_hit = edge_pol_i ? (filt_pin & ~filt_prev_reg) : (~filt_pin & filt_prev_reg);
    assign sync_trig = level_mode_i ? level_hit : edge_hit;

    // The unclocked path bypasses the filter and treats edge mode as a level.
    assign unclocked_path_select_cond_o = unclocked_i & (pin_i == (level_mode_i ? level_pol_i : edge_pol_i));

    assign trig_o = unclocked_i ? unclocked_path_select_cond_o : (run_i & sync_trig);

endmodule // pic_chan

`default_nettype wire

// *** bench/pic_pin_model.sv ***
// Model of the external pins that feed the pin interrupt controller.
// Assumes the bench asks for levels; the pins follow one clock edge later.
`default_nettype none
module pic_pin_model #(
    parameter NUM_CH = 4
) (
    // Clock
    input wire logic clk_i,
    // Requested and driven levels
    input wire logic [NUM_CH-1:0] want_i,
    output var logic [NUM_CH-1:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin_o = '0;
    always @(posedge clk_i) begin
        pin_o <= want_i;
    end
endmodule // pic_pin_model
`default_nettype wire

// *** bench/pic_top_monitor.sv ***
// Port checker for the pin interrupt controller.
// Assumes it is bound to pic_top and sees only that module's ports.
`default_nettype none
`include "pic_map.vh"
module pic_top_monitor #(
    parameter NUM_CH = 31
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`PIC_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [`PIC_DATA_W-1:0] wb_dat_i,
    input wire logic [`PIC_DATA_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [NUM_CH-1:0] ext_irq_pin_i,
    input wire logic system_rc_osc_on_i,
    input wire logic [NUM_CH-1:0] irq_o,
    input wire logic nmi_o,
    input wire logic wake_request_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack_once;
        disable iff (rst_i) s_take |=> s_pulse;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack is not a single pulse after a request");
    property p_ack_idle;
        disable iff (rst_i) !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without a request");
    property p_dat_idle;
        disable iff (rst_i) !wb_ack_o |-> wb_dat_o == '0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_reset_quiet;
        rst_i |=> !wb_ack_o && irq_o == '0 && !nmi_o && !wake_request_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");
    property p_irq_bit0;
        disable iff (rst_i) irq_o[0] == 1'b0;
    endproperty
    a_irq_bit0: assert property (p_irq_bit0) else $error("bit 0 raised a maskable request");
    property p_irq_wake;
        disable iff (rst_i) $rose(|irq_o) |-> wake_request_o;
    endproperty
    a_irq_wake: assert property (p_irq_wake) else $error("request without wake");
    property p_nmi_wake;
        disable iff (rst_i) $rose(nmi_o) |-> wake_request_o;
    endproperty
    a_nmi_wake: assert property (p_nmi_wake) else $error("nmi without wake");
    property p_wake_fall;
        disable iff (rst_i) $fell(wake_request_o) |-> irq_o == '0 && !nmi_o;
    endproperty
    a_wake_fall: assert property (p_wake_fall) else $error("request outlives wake");
endmodule // pic_top_monitor
bind pic_top pic_top_monitor #(.NUM_CH(NUM_CH)) u_mon (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .ext_irq_pin_i, .system_rc_osc_on_i, .irq_o, .nmi_o, .wake_request_o
);
`default_nettype wire

// *** bench/pic_top_test.sv ***
// Self-checking bench for the pin interrupt controller.
// Assumes four channels, the pin model and the bound port checker.
`default_nettype none
module pic_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NCH = 4;
    // Arbitrary revision value for this build.
    localparam logic [31:0] REV = 32'h0000_0a5a;
    localparam logic [9:0] RW_OFF [6] = '{10'h014, 10'h018, 10'h01c, 10'h020, 10'h024, 10'h028};
    localparam logic [9:0] ZERO_OFF [4] = '{10'h008, 10'h00c, 10'h038, 10'h02c};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] q;
    logic ack;
    logic [3:0] sel = 4'hf;
    logic [3:0] lanes = 4'hf;
    logic [NCH-1:0] want = 4'hc;
    logic [NCH-1:0] pins;
    logic osc = 1'b1;
    logic [NCH-1:0] irq;
    logic nmi;
    logic wake;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    pic_pin_model #(.NUM_CH(NCH)) u_pins (.clk_i(clk), .want_i(want), .pin_o(pins));
    pic_top #(.NUM_CH(NCH), .REVISION(REV)) u_dut (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_irq_pin_i(pins),
        .system_rc_osc_on_i(osc), .irq_o(irq), .nmi_o(nmi), .wake_request_o(wake));
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic [9:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= lanes;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e, input string name);
        bus(a, 1'b0, 32'h0);
        check(name, q, e);
    endtask
    task automatic pin(input logic [NCH-1:0] v);
        @(posedge clk);
        want <= v;
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic stop_test();
        if (num_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (ZERO_OFF[i]) rd(ZERO_OFF[i], 32'h0, "reset value");
        foreach (RW_OFF[i]) begin
            rd(RW_OFF[i], 32'h0, "rw reset");
            wr(RW_OFF[i], 32'hffff_ffff);
            rd(RW_OFF[i], 32'h0000_000f, "rw width");
            wr(RW_OFF[i], 32'h0);
        end
        lanes = 4'he;
        wr(10'h014, 32'hffff_ffff);
        lanes = 4'hf;
        rd(10'h014, 32'h0, "masked lane");
        wr(10'h02c, 32'hffff_ffff);
        rd(10'h02c, 32'h0, "unmapped");
        wr(10'h3fc, 32'h0);
        rd(10'h3fc, REV, "revision");
        wr(10'h000, 32'h5);
        wr(10'h000, 32'h0);
        rd(10'h008, 32'h5, "mask set");
        wr(10'h004, 32'h1);
        rd(10'h008, 32'h4, "mask clear");
        wr(10'h000, 32'hb);
        wr(10'h004, 32'h4);
        rd(10'h008, 32'hb, "mask state");
        // Every channel is set up before its input is enabled.
        wr(10'h014, 32'h9);
        wr(10'h018, 32'h2);
        wr(10'h01c, 32'h1);
        wr(10'h020, 32'h8);
        wr(10'h030, 32'hf);
        rd(10'h038, 32'hf, "enable state");
        rd(10'h00c, 32'h0, "idle flags");
        pin(4'he);
        look(3);
        check("early request", {28'h0, irq}, 32'h0);
        look(1);
        check("rising request", {28'h0, irq}, 32'h2);
        check("wake", {31'h0, wake}, 32'h1);
        pin(4'hc);
        look(4);
        rd(10'h00c, 32'h2, "flag held");
        wr(10'h010, 32'h2);
        rd(10'h00c, 32'h0, "flag clear");
        check("cleared request", {28'h0, irq}, 32'h0);
        pin(4'h8);
        look(4);
        check("masked request", {28'h0, irq}, 32'h0);
        check("masked wake", {31'h0, wake}, 32'h1);
        rd(10'h00c, 32'h4, "falling flag");
        wr(10'h034, 32'h4);
        rd(10'h00c, 32'h0, "disabled flag");
        rd(10'h038, 32'hb, "enable after clear");
        pin(4'hc);
        pin(4'h4);
        pin(4'hc);
        look(8);
        rd(10'h00c, 32'h0, "filtered glitch");
        pin(4'h4);
        look(4);
        check("filter delay", {28'h0, irq}, 32'h0);
        look(2);
        check("low level", {28'h0, irq}, 32'h8);
        pin(4'hc);
        look(8);
        wr(10'h010, 32'h8);
        rd(10'h00c, 32'h0, "level flag clear");
        pin(4'hd);
        look(4);
        check("nmi", {31'h0, nmi}, 32'h1);
        check("nmi not irq", {28'h0, irq}, 32'h0);
        pin(4'hc);
        look(4);
        wr(10'h010, 32'h1);
        look(2);
        check("nmi cleared", {31'h0, nmi}, 32'h0);
        wr(10'h034, 32'h2);
        wr(10'h028, 32'h2);
        wr(10'h030, 32'h2);
        osc <= 1'b0;
        look(4);
        pin(4'h6);
        look(3);
        check("unclocked early", {31'h0, wake}, 32'h0);
        look(1);
        check("unclocked wake", {31'h0, wake}, 32'h1);
        check("unclocked request", {28'h0, irq}, 32'h2);
        look(4);
        rd(10'h00c, 32'h2, "frozen sync flag");
        osc <= 1'b1;
        stop_test();
    end
endmodule // pic_top_test
`default_nettype wire
